// File: core/ufs_top.sv
// What this block does
// (RQ1) 512 words selected by nine address bits
// (RQ2) Address bit eight picks sector zero or one
// (RQ3) Each word holds sixteen bits
// (RQ4) Erase clears exactly one sector
// (RQ5) User erases sector before programming it
// (RQ6) Erasing one sector leaves other sector intact
// (RQ7) Internal oscillator times program and erase
// (RQ8) Oscillator divided by four drives output
// (RQ9) Output frequency fixed, not programmable
// (RQ10) Program or erase request runs algorithm alone
// (RQ11) User holds request until busy falls
// (RQ12) Busy high throughout program or erase
// (RQ13) Standard single reads and stream reads
// (RQ14) Address clock with select low increments
// (RQ15) Serial address and data pins, no parallel
// (RQ16) Address register nine bits, data sixteen
// (RQ17) Alternate access port programs and reads
// (RQ18) Inputs accept any clock net or routing
// (RQ19) Address clock with select high shifts
// (RQ20) User starts nothing while busy high
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ufs_consts.svh"

module ufs_top #(
	parameter logic [`UFS_CNT_W-1:0] PROG_TICKS  = `UFS_PROG_TICKS,
	parameter logic [`UFS_CNT_W-1:0] ERASE_TICKS = `UFS_ERASE_TICKS
) (
	input  wire logic                       clock_in,            // Clock
	input  wire logic                       rst_n_in,            // Reset
	input  wire logic                       clk_en_in,           // Enable
	input  wire logic                       addr_reg_clock_in,   // Addr clk
	input  wire logic                       addr_shift_sel_in,   // Addr mode
	input  wire logic                       addr_serial_in,      // Addr bit
	input  wire logic                       data_reg_clock_in,   // Data clk
	input  wire logic                       data_shift_sel_in,   // Data mode
	input  wire logic                       data_serial_in,      // Data bit
	input  wire logic                       program_in,          // Program
	input  wire logic                       erase_in,            // Erase
	output      logic                       data_serial_out,     // Data MSB
	output      logic                       busy_out,            // Busy
	output      logic                       osc_out,             // Osc / 4
	input  wire logic [`UFS_AVS_ADDR_W-1:0] avs_address_in,      // Address
	input  wire logic                       avs_read_in,         // Read
	input  wire logic                       avs_write_in,        // Write
	input  wire logic [`UFS_AVS_DATA_W-1:0] avs_writedata_in,    // Wr data
	input  wire logic [3:0]                 avs_byteenable_in,   // Lanes
	output      logic [`UFS_AVS_DATA_W-1:0] avs_readdata_out,    // Rd data
	output      logic                       avs_waitrequest_out  // Stall
);

	// ------------------------------------------------------------------
	// Storage and state
	// ------------------------------------------------------------------
	localparam int SECTOR_WORDS = 1 << `UFS_SECTOR_BIT;  // Words a sector

	logic [`UFS_DATA_W-1:0] mem [`UFS_WORDS];  // Flash array, see (RQ1)

	ufs_pkg::ufs_state_t    q;            // Registered state
	ufs_pkg::ufs_state_t    d;            // Next state
	logic [`UFS_SY_N-1:0]   pins;         // Raw pin vector
	logic [`UFS_SY_N-1:0]   rise;         // Rising edges of agreed pins
	logic                   mem_we;       // Program strobe
	logic                   mem_er;       // Sector erase strobe
	logic                   er_sector;    // Sector to erase
	logic [`UFS_ADDR_W-1:0] mem_wa;       // Program address
	logic [`UFS_DATA_W-1:0] mem_wd;       // Program word
	logic                   wr_take;      // Avalon write completes now
	logic                   rd_take;      // Avalon read captured now, granted next cycle
	logic                   user_start;   // Pin program or erase request level, any state
	logic [`UFS_CNT_W-1:0]  limit;        // Ticks for current op
	logic [`UFS_AVS_DATA_W-1:0] ctrl_wr;  // Control write after lanes

	ufs_osc_if osc ();  // Oscillator carrier

	// ------------------------------------------------------------------
	// Internal oscillator
	// ------------------------------------------------------------------
	ufs_osc_gen u_osc (
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.clk_en_in (clk_en_in),
		.osc       (osc.gen)
	);

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Merge a write into an old word by byte lane
	function automatic logic [`UFS_AVS_DATA_W-1:0] lane_merge(
		input logic [`UFS_AVS_DATA_W-1:0] old_w,
		input logic [`UFS_AVS_DATA_W-1:0] new_w,
		input logic [3:0]                 be
	);
		logic [`UFS_AVS_DATA_W-1:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Zero extend an address into a bus word
	function automatic logic [`UFS_AVS_DATA_W-1:0] ext_addr(
		input logic [`UFS_ADDR_W-1:0] a
	);
		return {{(`UFS_AVS_DATA_W - `UFS_ADDR_W){1'b0}}, a};
	endfunction

	// Zero extend a data word into a bus word
	function automatic logic [`UFS_AVS_DATA_W-1:0] ext_data(
		input logic [`UFS_DATA_W-1:0] w
	);
		return {{(`UFS_AVS_DATA_W - `UFS_DATA_W){1'b0}}, w};
	endfunction

	// ------------------------------------------------------------------
	// Pin vector, any clock net or routing may drive these
	// ------------------------------------------------------------------
	always_comb begin
		pins = '0;
		pins[`UFS_SY_ADCLK] = addr_reg_clock_in;
		pins[`UFS_SY_ARSEL] = addr_shift_sel_in;
		pins[`UFS_SY_ARDIN] = addr_serial_in;
		pins[`UFS_SY_DRCLK] = data_reg_clock_in;
		pins[`UFS_SY_DRSEL] = data_shift_sel_in;
		pins[`UFS_SY_DRDIN] = data_serial_in;
		pins[`UFS_SY_PROG]  = program_in;
		pins[`UFS_SY_ERASE] = erase_in;
	end

	// ------------------------------------------------------------------
	// Next state logic
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		mem_we = 1'b0;
		mem_er = 1'b0;
		er_sector = q.op_addr[`UFS_SECTOR_BIT];
		mem_wa = q.op_addr;
		mem_wd = q.op_data;
		ctrl_wr = '0;

		// Three stage sync, level moves when stages two and three agree
		d.sy0 = pins;                                    // see (RQ18)
		d.sy1 = q.sy0;
		d.sy2 = q.sy1;
		d.filt = (q.sy1 & q.sy2) | ((q.sy1 ^ q.sy2) & q.filt);
		rise = d.filt & ~q.filt;

		// Avalon handshake: grant one cycle after the request appears
		rd_take = avs_read_in && q.wait_r;
		wr_take = avs_write_in && !q.wait_r;
		if (!q.wait_r) begin
			d.wait_r = 1'b1;                 // Release after completion
		end else if (avs_read_in || avs_write_in) begin
			d.wait_r = 1'b0;                 // Answer next cycle
		end

		// Read mux, unmapped offsets read zero
		if (rd_take) begin
			case (avs_address_in)
				`UFS_REG_ADDR: begin
					d.rdata = ext_addr(q.sw_addr);
				end
				`UFS_REG_WDATA: begin
					d.rdata = ext_data(q.sw_wdata);
				end
				`UFS_REG_RDATA: begin
					d.rdata = ext_data(q.sw_rdata);
				end
				`UFS_REG_STATUS: begin
					d.rdata = '0;
					d.rdata[`UFS_STAT_BUSY] = q.busy;
					d.rdata[`UFS_STAT_WREL] = (q.fsm == ufs_pkg::UFS_WREL);
				end
				default: begin
					d.rdata = '0;            // Control and unmapped
				end
			endcase
		end

		// Register writes; unmapped offsets are ignored
		if (wr_take) begin
			case (avs_address_in)
				`UFS_REG_ADDR: begin
					d.sw_addr = (`UFS_ADDR_W)'(lane_merge(
						ext_addr(q.sw_addr), avs_writedata_in,
						avs_byteenable_in));
				end
				`UFS_REG_WDATA: begin
					d.sw_wdata = (`UFS_DATA_W)'(lane_merge(
						ext_data(q.sw_wdata), avs_writedata_in,
						avs_byteenable_in));
				end
				`UFS_REG_CTRL: begin
					ctrl_wr = lane_merge('0, avs_writedata_in,
						avs_byteenable_in);
				end
				default: begin
				end
			endcase
		end

		user_start = d.filt[`UFS_SY_PROG] || d.filt[`UFS_SY_ERASE];
		limit = (q.fsm == ufs_pkg::UFS_ERASE) ? ERASE_TICKS : PROG_TICKS;

		// Sequencer
		case (q.fsm)
			ufs_pkg::UFS_IDLE: begin
				// Serial address register, nine bits
				if (rise[`UFS_SY_ADCLK]) begin
					if (q.filt[`UFS_SY_ARSEL]) begin
						d.addr = {q.addr[`UFS_ADDR_W-2:0],
							q.filt[`UFS_SY_ARDIN]};  // see (RQ19) (RQ16)
					end else begin
						d.addr = q.addr + 9'h001;  // see (RQ14) (RQ13)
					end
				end
				// Serial data register, sixteen bits
				if (rise[`UFS_SY_DRCLK]) begin
					if (q.filt[`UFS_SY_DRSEL]) begin
						d.data = {q.data[`UFS_DATA_W-2:0],
							q.filt[`UFS_SY_DRDIN]};  // see (RQ15) (RQ16)
					end else begin
						d.data = mem[q.addr];      // see (RQ13) (RQ3)
					end
				end
				// Alternate port single word read
				if (ctrl_wr[`UFS_CTRL_READ]) begin
					d.sw_rdata = mem[q.sw_addr];   // see (RQ17)
				end
				// Start an operation; pin program wins, then pin erase
				if (d.filt[`UFS_SY_PROG]) begin
					d.fsm = ufs_pkg::UFS_PROG;     // see (RQ10)
					d.op_addr = q.addr;
					d.op_data = q.data;
					d.op_user = 1'b1;
				end else if (d.filt[`UFS_SY_ERASE]) begin
					d.fsm = ufs_pkg::UFS_ERASE;    // see (RQ10)
					d.op_addr = q.addr;
					d.op_user = 1'b1;
				end else if (ctrl_wr[`UFS_CTRL_PROG]) begin
					d.fsm = ufs_pkg::UFS_PROG;     // see (RQ17)
					d.op_addr = q.sw_addr;
					d.op_data = q.sw_wdata;
					d.op_user = 1'b0;
				end else if (ctrl_wr[`UFS_CTRL_ERASE]) begin
					d.fsm = ufs_pkg::UFS_ERASE;    // see (RQ17)
					d.op_addr = q.sw_addr;
					d.op_user = 1'b0;
				end
				if (d.fsm != ufs_pkg::UFS_IDLE) begin
					d.busy = 1'b1;                 // see (RQ12)
					d.cnt = '0;
				end
			end
			ufs_pkg::UFS_PROG, ufs_pkg::UFS_ERASE: begin
				// Time the algorithm on oscillator ticks
				if (osc.tick) begin
					if (q.cnt == limit - 16'h0001) begin
						if (q.fsm == ufs_pkg::UFS_PROG) begin
							mem_we = 1'b1;         // see (RQ5)
						end else begin
							mem_er = 1'b1;         // see (RQ4) (RQ2)
						end
						d.busy = 1'b0;             // see (RQ12)
						d.cnt = '0;
						d.fsm = q.op_user ? ufs_pkg::UFS_WREL
							: ufs_pkg::UFS_IDLE;
					end else begin
						d.cnt = q.cnt + 16'h0001;  // see (RQ7)
					end
				end
			end
			ufs_pkg::UFS_WREL: begin
				// Wait until the pin request is dropped, see (RQ11)
				if (!user_start) begin
					d.fsm = ufs_pkg::UFS_IDLE;
				end
			end
			default: begin
				d.fsm = ufs_pkg::UFS_IDLE;
				d.busy = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.wait_r <= 1'b1;
		end else if (clk_en_in) begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Flash array writes, not reset since contents are nonvolatile
	// ------------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_n_in && clk_en_in) begin
			if (mem_we) begin
				// Programming only clears bits
				mem[mem_wa] <= mem[mem_wa] & mem_wd;      // see (RQ5)
			end
			if (mem_er) begin
				// Only the words of the chosen sector change
				for (int i = 0; i < SECTOR_WORDS; i++) begin
					mem[{er_sector, (`UFS_SECTOR_BIT)'(i)}]
						<= `UFS_ERASED_WORD;             // see (RQ6)
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs, each straight from a flip-flop
	// ------------------------------------------------------------------
	assign data_serial_out     = q.data[`UFS_DATA_W-1];  // see (RQ15)
	assign busy_out            = q.busy;                 // see (RQ12)
	assign osc_out             = osc.clk_out;            // see (RQ8)
	assign avs_readdata_out    = q.rdata;
	assign avs_waitrequest_out = q.wait_r;

endmodule

// File: pkg/ufs_consts.svh
`ifndef UFS_CONSTS_SVH
`define UFS_CONSTS_SVH

// ------------------------------------------------------------------
// Array geometry, oscillator timing and pin vector bits
// ------------------------------------------------------------------
`define UFS_ADDR_W        9
`define UFS_DATA_W        16
`define UFS_WORDS         512
`define UFS_SECTOR_BIT    8
`define UFS_ERASED_WORD   16'hFFFF
`define UFS_CLK_FREQ_KHZ  100000
`define UFS_OSC_FREQ_KHZ  16667
`define UFS_OSC_DIV       ((`UFS_CLK_FREQ_KHZ + `UFS_OSC_FREQ_KHZ / 2) / `UFS_OSC_FREQ_KHZ)
`define UFS_OSC_DIV_W     8
`define UFS_CNT_W         16
`define UFS_PROG_TICKS    16'h0040
`define UFS_ERASE_TICKS   16'h0400
`define UFS_SY_ADCLK      0
`define UFS_SY_ARSEL      1
`define UFS_SY_ARDIN      2
`define UFS_SY_DRCLK      3
`define UFS_SY_DRSEL      4
`define UFS_SY_DRDIN      5
`define UFS_SY_PROG       6
`define UFS_SY_ERASE      7
`define UFS_SY_N          8

// ------------------------------------------------------------------
// Avalon-MM register map (byte addresses) and fields
// ------------------------------------------------------------------
`define UFS_AVS_ADDR_W    5
`define UFS_AVS_DATA_W    32
`define UFS_REG_CTRL      5'h00
`define UFS_REG_ADDR      5'h04
`define UFS_REG_WDATA     5'h08
`define UFS_REG_RDATA     5'h0C
`define UFS_REG_STATUS    5'h10
`define UFS_CTRL_PROG     0
`define UFS_CTRL_ERASE    1
`define UFS_CTRL_READ     2
`define UFS_STAT_BUSY     0
`define UFS_STAT_WREL     1

`endif

// File: pkg/ufs_pkg.sv
`include "ufs_consts.svh"

package ufs_pkg;

	// ------------------------------------------------------------------
	// Operation sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		UFS_IDLE,
		UFS_PROG,
		UFS_ERASE,
		UFS_WREL
	} ufs_fsm_t;

	// ------------------------------------------------------------------
	// Complete state of the top module
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [`UFS_SY_N-1:0]       sy0;      // First sync stage
		logic [`UFS_SY_N-1:0]       sy1;      // Second sync stage
		logic [`UFS_SY_N-1:0]       sy2;      // Third sync stage
		logic [`UFS_SY_N-1:0]       filt;     // Agreed pin levels
		ufs_fsm_t                   fsm;      // Sequencer state
		logic                       busy;     // Busy flag
		logic [`UFS_CNT_W-1:0]      cnt;      // Oscillator tick count
		logic [`UFS_ADDR_W-1:0]     addr;     // Serial address register
		logic [`UFS_DATA_W-1:0]     data;     // Serial data register
		logic [`UFS_ADDR_W-1:0]     op_addr;  // Latched op address
		logic [`UFS_DATA_W-1:0]     op_data;  // Latched program word
		logic                       op_user;  // Op came from pins
		logic [`UFS_ADDR_W-1:0]     sw_addr;  // Software address
		logic [`UFS_DATA_W-1:0]     sw_wdata; // Software write word
		logic [`UFS_DATA_W-1:0]     sw_rdata; // Software read word
		logic                       wait_r;   // Avalon waitrequest
		logic [`UFS_AVS_DATA_W-1:0] rdata;    // Avalon read data
	} ufs_state_t;

	// ------------------------------------------------------------------
	// State of the oscillator module
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [`UFS_OSC_DIV_W-1:0]  div;      // Clock divider count
		logic                       tick;     // Internal oscillator tick
		logic                       phase;    // Tick pair phase
		logic                       clk_out;  // Divide by four output
	} ufs_osc_t;

endpackage

// File: pkg/ufs_osc_if.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Oscillator signals between generator and sequencer
// ------------------------------------------------------------------
interface ufs_osc_if;
	logic tick;     // One cycle per internal oscillator period
	logic clk_out;  // Internal oscillator divided by four

	modport gen (output tick, output clk_out);
	modport use_side (input tick, input clk_out);
endinterface

// File: core/ufs_osc_gen.sv
`timescale 1ns/1ps
`include "ufs_consts.svh"

module ufs_osc_gen #(
	parameter logic [`UFS_OSC_DIV_W-1:0] DIV = (`UFS_OSC_DIV_W)'(`UFS_OSC_DIV)
) (
	input  wire logic  clock_in,   // System clock
	input  wire logic  rst_n_in,   // Synchronous reset, active low
	input  wire logic  clk_en_in,  // Clock enable
	ufs_osc_if.gen     osc         // Oscillator outputs
);

	ufs_pkg::ufs_osc_t q;  // Registered state
	ufs_pkg::ufs_osc_t d;  // Next state

	// ------------------------------------------------------------------
	// Tick every DIV clocks, output toggles every second tick
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.div == DIV - 8'h01) begin
			d.div = '0;
			d.tick = 1'b1;
			d.phase = ~q.phase;
			if (q.phase) begin
				d.clk_out = ~q.clk_out;  // see (RQ8)
			end
		end else begin
			d.div = q.div + 8'h01;
		end
	end

	// Register the state
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else if (clk_en_in) begin
			q <= d;
		end
	end

	// Free running, no frequency control: see (RQ9)
	assign osc.tick = q.tick;        // see (RQ7)
	assign osc.clk_out = q.clk_out;

endmodule

// File: bench/ufs_chk.sv
`timescale 1ns/1ps
`include "ufs_consts.svh"

// ------------------------------------------------------------------
// Port checks of the flash block
// ------------------------------------------------------------------
module ufs_chk #(
	parameter logic [`UFS_CNT_W-1:0] PROG_TICKS  = `UFS_PROG_TICKS,
	parameter logic [`UFS_CNT_W-1:0] ERASE_TICKS = `UFS_ERASE_TICKS
) (
	input wire logic                       clock_in,            // Clock
	input wire logic                       rst_n_in,            // Reset
	input wire logic                       program_in,          // Program
	input wire logic                       erase_in,            // Erase
	input wire logic                       data_reg_clock_in,   // Data clk
	input wire logic                       data_serial_out,     // Data MSB
	input wire logic                       busy_out,            // Busy
	input wire logic                       osc_out,             // Osc / 4
	input wire logic                       avs_read_in,         // Read
	input wire logic                       avs_write_in,        // Write
	input wire logic [`UFS_AVS_DATA_W-1:0] avs_readdata_out,    // Rd data
	input wire logic                       avs_waitrequest_out  // Stall
);
	localparam int BUSY_MIN = (int'(PROG_TICKS) - 1) * 6;  // Shortest op
	localparam int BUSY_MAX = (int'(ERASE_TICKS) + 2) * 6; // Longest op
	logic [15:0] busy_cnt_q; // Cycles busy has stood
	logic [4:0]  osc_cnt_q;  // Cycles since last oscillator change
	logic        osc_q;      // Oscillator level one cycle back
	logic        osc_seen_q; // First oscillator change seen

	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	// Counters for busy length and oscillator half period
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			busy_cnt_q <= '0;
			osc_cnt_q  <= '0;
			osc_q      <= '0;
			osc_seen_q <= '0;
		end else begin
			busy_cnt_q <= busy_out ? busy_cnt_q + 16'h0001 : 16'h0000;
			osc_q      <= osc_out;
			osc_seen_q <= osc_seen_q | (osc_out != osc_q);
			osc_cnt_q  <= (osc_out != osc_q) ? 5'h00 : osc_cnt_q + 5'h01;
		end
	end

	rst_quiet_a: assert property (
		$rose(rst_n_in) |-> !busy_out && !osc_out && !data_serial_out
			&& avs_waitrequest_out
	) else $error("reset state");
	wait_answer_a: assert property (
		(avs_read_in || avs_write_in) && avs_waitrequest_out
			|=> !avs_waitrequest_out
	) else $error("no answer");
	wait_once_a: assert property (
		!avs_waitrequest_out |=> avs_waitrequest_out
	) else $error("wait low too long");
	wait_cause_a: assert property (
		!avs_waitrequest_out |-> $past(avs_read_in) || $past(avs_write_in)
	) else $error("wait low unasked");
	rdata_hold_a: assert property (
		$changed(avs_readdata_out) |-> avs_read_in && !avs_waitrequest_out
	) else $error("rdata moved");
	busy_go_a: assert property (
		($rose(program_in) || $rose(erase_in)) && !busy_out
			|-> ##[1:8] busy_out
	) else $error("no busy");
	busy_len_a: assert property (
		$fell(busy_out) |-> busy_cnt_q >= BUSY_MIN && busy_cnt_q <= BUSY_MAX
	) else $error("busy length");
	osc_period_a: assert property (
		osc_seen_q |-> ((osc_out != osc_q) == (osc_cnt_q == 5'h0B))
			&& osc_cnt_q < 5'h0C
	) else $error("osc half period");
	dout_cause_a: assert property (
		$changed(data_serial_out)
			|-> $past(data_reg_clock_in, 2) || $past(data_reg_clock_in, 6)
	) else $error("dout without clock");
endmodule

// File: bench/ufs_user_mdl.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// User logic on the serial side of the flash block
// ------------------------------------------------------------------
module ufs_user_mdl (
	input  wire logic clock_in,     // System clock
	input  wire logic busy_in,      // Busy from block
	input  wire logic dout_in,      // Data register MSB
	output wire logic addr_clk_out, // Address register clock
	output wire logic addr_sel_out, // Address shift select
	output wire logic addr_bit_out, // Serial address bit
	output wire logic data_clk_out, // Data register clock
	output wire logic data_sel_out, // Data shift select
	output wire logic data_bit_out, // Serial data bit
	output wire logic prog_out,     // Program request
	output wire logic erase_out     // Erase request
);
	logic [1:0] clk_q = '0; // Serial clocks, index 0 address, 1 data
	logic [1:0] sel_q = '0; // Shift selects
	logic [1:0] bit_q = '0; // Serial bits
	logic [1:0] req_q = '0; // Index 0 program, 1 erase

	assign {data_clk_out, addr_clk_out} = clk_q;
	assign {data_sel_out, addr_sel_out} = sel_q;
	assign {data_bit_out, addr_bit_out} = bit_q;
	assign {erase_out, prog_out}        = req_q;

	// One serial clock, six cycles of set-up and hold around it
	task automatic step(input int dp, input logic sel, input logic b);
		@(posedge clock_in);
		sel_q[dp] <= sel;
		bit_q[dp] <= b;
		repeat (6) @(posedge clock_in);
		clk_q[dp] <= 1'h1;
		repeat (6) @(posedge clock_in);
		clk_q[dp] <= 1'h0;
		bit_q[dp] <= ~b; // Stale bit is not left on the line
	endtask

	// Address in, most significant bit first
	task automatic send_addr(input logic [8:0] a);
		for (int i = 8; i >= 0; i--) begin
			step(0, 1'h1, a[i]);
		end
	endtask

	// Program word in, most significant bit first
	task automatic send_word(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			step(1, 1'h1, w[i]);
		end
	endtask

	// Load the addressed word, then shift it out
	task automatic read_word(output logic [15:0] w);
		step(1, 1'h0, 1'h0);
		w[15] = dout_in;
		for (int i = 14; i >= 0; i--) begin
			step(1, 1'h1, 1'h0);
			w[i] = dout_in;
		end
	endtask

	// Move on to the next location of a stream read
	task automatic inc;
		step(0, 1'h0, 1'h0);
	endtask

	// Program or erase request, held until busy falls
	task automatic op(input int er, output logic seen);
		int n = 0;
		@(posedge clock_in);
		req_q[er] <= 1'h1;
		while (busy_in !== 1'h1 && n < 20) begin
			@(posedge clock_in);
			n++;
		end
		seen = busy_in;
		while (busy_in !== 1'h0 && n < 400) begin
			@(posedge clock_in);
			n++;
		end
		req_q[er] <= 1'h0;
		repeat (10) @(posedge clock_in);
	endtask
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
`include "ufs_consts.svh"

bind ufs_top ufs_chk #(
	.PROG_TICKS (PROG_TICKS),
	.ERASE_TICKS(ERASE_TICKS)
) chk (.*);

module tb;
	localparam logic [15:0] P_TICKS = 16'h0002; // Short program time
	localparam logic [15:0] E_TICKS = 16'h0004; // Short erase time
	localparam int          LIMIT   = 40000;    // Cycle ceiling
	logic        clock_in = '0;         // Clock
	logic        rst_n_in = '0;         // Reset
	logic        avs_read_in = '0;      // Bus read
	logic        avs_write_in = '0;     // Bus write
	logic [4:0]  avs_address_in = '0;   // Bus address
	logic [31:0] avs_writedata_in = '0; // Bus write data
	logic [31:0] avs_readdata_out;    // Bus read data
	logic        avs_waitrequest_out; // Bus stall
	logic        busy_out;            // Busy
	logic        osc_out;             // Oscillator output
	logic        dout;                // Serial data out
	wire  [7:0]  pins;                // Model to block pins
	int          error_cnt = 0;       // Mismatches
	int          n_tests = 0;         // Comparisons
	int          cyc = 0;             // Cycles run

	ufs_user_mdl u (
		.clock_in, .busy_in(busy_out), .dout_in(dout),
		.addr_clk_out(pins[0]), .addr_sel_out(pins[1]),
		.addr_bit_out(pins[2]), .data_clk_out(pins[3]),
		.data_sel_out(pins[4]), .data_bit_out(pins[5]),
		.prog_out(pins[6]), .erase_out(pins[7])
	);

	ufs_top #(.PROG_TICKS(P_TICKS), .ERASE_TICKS(E_TICKS)) dut (
		.clock_in, .rst_n_in, .clk_en_in(1'h1),
		.addr_reg_clock_in(pins[0]), .addr_shift_sel_in(pins[1]),
		.addr_serial_in(pins[2]), .data_reg_clock_in(pins[3]),
		.data_shift_sel_in(pins[4]), .data_serial_in(pins[5]),
		.program_in(pins[6]), .erase_in(pins[7]),
		.data_serial_out(dout), .busy_out, .osc_out,
		.avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
		.avs_byteenable_in(4'hF), .avs_readdata_out, .avs_waitrequest_out
	);

	// Clock and cycle ceiling
	always #5 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			error_cnt++;
			final_report();
		end
	end

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Counts and verdict
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One bus transfer, held until waitrequest is sampled low
	task automatic av(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge clock_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		do @(posedge clock_in);
		while (avs_waitrequest_out !== 1'h0 && ++n < 50);
		q = avs_readdata_out;
		avs_write_in <= 1'h0;
		avs_read_in <= 1'h0;
		if (n == 50)
			error_cnt++;
	endtask

	// Program (er 0) or erase (er 1) through the serial pins
	task automatic pgm(input logic [8:0] a, input logic [15:0] w,
		input int er);
		logic seen;
		u.send_addr(a);
		if (er == 0)
			u.send_word(w);
		u.op(er, seen);
		chk("busy seen", 32'h1, {31'h0, seen});
	endtask

	// Serial read, with or without a fresh address
	task automatic rd(input logic ld, input logic [8:0] a,
		input logic [15:0] w);
		logic [15:0] r;
		if (ld)
			u.send_addr(a);
		u.read_word(r);
		chk("word", {16'h0, w}, {16'h0, r});
	endtask

	task automatic t_reset;
		logic [31:0] q;
		chk("busy", 32'h0, {31'h0, busy_out});
		chk("osc", 32'h0, {31'h0, osc_out});
		av(1'h0, `UFS_REG_STATUS, 32'h0, q);
		chk("status", 32'h0, q);
		$display("test reset done");
	endtask

	task automatic t_sectors;
		pgm(9'h0FF, 16'h0, 1);
		pgm(9'h100, 16'h0, 1);
		pgm(9'h0FF, 16'hA5C3, 0);
		pgm(9'h100, 16'h5A3C, 0);
		rd(1'h1, 9'h0FF, 16'hA5C3);
		rd(1'h1, 9'h100, 16'h5A3C);
		pgm(9'h000, 16'h0, 1);
		rd(1'h1, 9'h0FF, 16'hFFFF);
		rd(1'h1, 9'h100, 16'h5A3C);
		$display("test sectors done");
	endtask

	task automatic t_stream;
		pgm(9'h1FE, 16'h1357, 0);
		pgm(9'h1FF, 16'h2468, 0);
		rd(1'h1, 9'h1FE, 16'h1357);
		u.inc();
		rd(1'h0, 9'h1FF, 16'h2468);
		$display("test stream done");
	endtask

	task automatic t_soft;
		logic [31:0] q;
		int n;
		av(1'h1, `UFS_REG_ADDR, 32'hFFFF_FFFF, q);
		av(1'h0, `UFS_REG_ADDR, 32'h0, q);
		chk("addr width", 32'h1FF, q);
		av(1'h1, `UFS_REG_ADDR, 32'h10, q);
		av(1'h1, 5'h14, 32'h1FF, q);
		av(1'h0, `UFS_REG_ADDR, 32'h0, q);
		chk("unmapped", 32'h10, q);
		av(1'h1, `UFS_REG_WDATA, 32'hF0, q);
		av(1'h1, `UFS_REG_CTRL, 32'h1, q);
		repeat (4) @(posedge clock_in);
		n = 0;
		do av(1'h0, `UFS_REG_STATUS, 32'h0, q);
		while (q[`UFS_STAT_BUSY] !== 1'h0 && ++n < 100);
		av(1'h1, `UFS_REG_CTRL, 32'h4, q);
		av(1'h0, `UFS_REG_RDATA, 32'h0, q);
		chk("sw read", 32'hF0, q);
		rd(1'h1, 9'h010, 16'h00F0);
		$display("test software port done");
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge clock_in);
		rst_n_in <= 1'h1;
		@(posedge clock_in);
		t_reset();
		t_sectors();
		t_stream();
		t_soft();
		final_report();
	end
endmodule
